// ===== verilog/bssl_consts.svh
// Constants of the boot selector and serial record loader.
`ifndef BSSL_CONSTS_SVH
`define BSSL_CONSTS_SVH
`define BSSL_CLK_MHZ 250
`define BSSL_APP_START 16'h0000
`define BSSL_BOOT_ROM_BASE 16'hf800
`define BSSL_BOOT_ROM_TOP 16'hffff
`define BSSL_FLASH_TOP_16K 16'h3fff
`define BSSL_FLASH_TOP_32K 16'h7fff
`define BSSL_SBV_DEFAULT 8'hfc
`define BSSL_BSB_DEFAULT 8'hff
`define BSSL_STRAP_HOLD_CYC 5'd24
`define BSSL_MAX_DATA 8'h10
`define BSSL_CH_U 8'h55
`define BSSL_CH_COLON 8'h3a
`define BSSL_CH_DOT 8'h2e
`define BSSL_CH_X 8'h58
`define BSSL_CH_R 8'h52
`define BSSL_REC_DATA 8'h00
`define BSSL_REC_EOF 8'h01
`define BSSL_REC_OSC 8'h02
`define BSSL_FIFO_DEPTH 8
`endif

// ===== verilog/bssl_pkg.sv
// Types of the boot selector and serial record loader.
package bssl_pkg;
  typedef enum logic [3:0] {
    BSSL_BAUD_IDLE, BSSL_BAUD_MEAS, BSSL_WAIT_COLON, BSSL_GET_HEX,
    BSSL_EXEC, BSSL_PROG, BSSL_WAIT_ACK, BSSL_REPLY
  } bssl_state_t;
  typedef enum logic [1:0] {
    BSSL_RX_IDLE, BSSL_RX_START, BSSL_RX_DATA, BSSL_RX_STOP
  } bssl_rx_t;
endpackage : bssl_pkg

// ===== verilog/bssl_fifo.sv
// Small valid/ready FIFO that carries transmit characters.
`timescale 1ns/1ps
`default_nettype none
module bssl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Space is free.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  output logic out_valid, // Data is waiting.
  input wire logic out_ready, // Reader takes data.
  output logic [WIDTH-1:0] out_data // Read data.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, rp_q;
  logic [WIDTH-1:0] rd_q;
  logic rdv_q;
  logic wr, rd, empty;

  // ----------------------------------------
  // Pointer and flag logic
  // ----------------------------------------
  assign empty = (wp_q == rp_q);
  assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign wr = in_valid && in_ready;
  assign rd = !empty && (!rdv_q || out_ready);
  assign out_valid = rdv_q;
  assign out_data = rd_q;

  // Storage array and registered read port.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      rdv_q <= 1'b0;
      rd_q <= '0;
    end
    else
    begin
      if (wr)
      begin
        mem_q[wp_q[AW-1:0]] <= in_data;
        wp_q <= wp_q + 1'b1;
      end
      if (rd)
      begin
        rd_q <= mem_q[rp_q[AW-1:0]];
        rp_q <= rp_q + 1'b1;
        rdv_q <= 1'b1;
      end
      else if (out_ready)
      begin
        rdv_q <= 1'b0;
      end
    end
  end
endmodule : bssl_fifo
`default_nettype wire

// ===== verilog/bssl_loader.sv
// Boot selection and serial hex record loader.
`timescale 1ns/1ps
`default_nettype none
`include "bssl_consts.svh"
// Contract
// - External access high: fetch internal, above flash top go external.
// - External access low: every fetch goes external.
// - Boot ROM occupies F800h through FFFFh.
// - Without strap, jump bit set boots 0000h, else F800h; the code instead starts straight at 0000h or the vector address.
// - Boot code with zero status byte continues at 0000h.
// - Nonzero status jumps to vector high byte, low byte 00h.
// - Software boot vector defaults to FCh, the serial loader.
// - Strobe low, access high, latch enable high forces the loader.
// - Host sends U; device measures a bit time for baud.
// - Every received character is echoed while the loader runs.
// - Only colon-led ASCII hex records are accepted.
// - A record holds at most 16 data bytes.
// - Type 00 programs data; type 01 is acknowledged only.
// - Act on a record only after its checksum is compared.
// - Checksum mismatch answers X and skips the record.
// - Good record executes and answers a period.
// - Data record answers R when any byte fails to program.
// - Type 02 is acknowledged and its contents ignored.
// - Programming uses only the serial transmit and receive pins.
module bssl_loader
  import bssl_pkg::*;
#(
  parameter bit FLASH_32K = 1'b1
) (
  input wire logic SYS_CLK, // Core clock, 250 MHz.
  input wire logic RST_N, // Asynchronous reset, active low.
  input wire logic RESET_FALL, // Pulse: external reset pin fell.
  input wire logic EXTERNAL_ACCESS_N, // Pin level, high means internal.
  input wire logic PROGRAM_STORE_STROBE_N, // Strap pin level.
  input wire logic ADDR_LATCH_EN, // Strap pin level.
  input wire logic BOOT_LOADER_JUMP_BIT, // Bit of the security byte.
  input wire logic [7:0] BOOT_STATUS_BYTE, // Stored status byte.
  input wire logic [7:0] SOFTWARE_BOOT_VECTOR, // Stored vector.
  input wire logic [15:0] FETCH_ADDR, // Program fetch address.
  input wire logic RXD, // Serial receive line.
  input wire logic PROG_DONE, // Pulse: flash byte write finished.
  input wire logic PROG_OK, // Byte verified, with PROG_DONE.
  output logic FETCH_EXTERNAL, // Fetch goes to external memory.
  output logic FETCH_BOOT_ROM, // Fetch hits the boot ROM.
  output logic [15:0] START_ADDR, // Execution start address.
  output logic START_VALID, // Start address is decided.
  output logic LOADER_ACTIVE, // Serial loader is running.
  output logic TXD, // Serial transmit line.
  output logic PROG_REQ, // Pulse: write one flash byte.
  output logic [15:0] PROG_ADDR, // Flash byte address.
  output logic [7:0] PROG_DATA // Flash byte value.
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic ext; logic rom; logic [15:0] start; logic sv; logic act;
    logic [4:0] hold; bssl_state_t st; bssl_rx_t rxs;
    logic [15:0] bitlen; logic [15:0] rxcnt; logic [3:0] rxbit;
    logic [7:0] rxsh; logic rxline;
    logic hinib; logic [3:0] nib; logic [5:0] idx; logic [7:0] sum;
    logic [7:0] cnt; logic [15:0] addr; logic [7:0] rtyp;
    logic [15:0][7:0] dat; logic [4:0] pi; logic fail;
    logic preq; logic [15:0] paddr; logic [7:0] pdat;
    logic txbusy; logic [15:0] txcnt; logic [3:0] txbit;
    logic [9:0] txsh; logic txd;
  } bssl_s_t;
  bssl_s_t q, d;
  logic rx_done;
  logic [7:0] rx_byte;
  logic push;
  logic [7:0] push_data;
  logic f_rdy, f_vld, f_take;
  logic [7:0] f_data;

  // Converts an ASCII hex digit; bit 4 flags a non-hex character.
  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
    if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b0, 4'(c[3:0] + 4'h9)};
    return 5'h10;
  endfunction : hexval

  // ----------------------------------------
  // Transmit FIFO
  // ----------------------------------------
  bssl_fifo #(.WIDTH(8), .DEPTH(`BSSL_FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_ready(f_rdy),
    .in_data(push_data),
    .out_valid(f_vld),
    .out_ready(f_take),
    .out_data(f_data)
  );
  assign f_take = !q.txbusy && q.st != BSSL_BAUD_IDLE
                  && q.st != BSSL_BAUD_MEAS;

  // Receiver completion pulse used by the command logic.
  assign rx_done = (q.rxs == BSSL_RX_STOP) && (q.rxcnt == q.bitlen);
  assign rx_byte = q.rxsh;

  // Next state of the whole block.
  always_comb
  begin
    logic [4:0] hv;
    logic [7:0] byte_v;
    hv = hexval(rx_byte);
    byte_v = {q.nib, hv[3:0]};
    d = q;
    push = 1'b0;
    push_data = 8'h00;
    d.preq = 1'b0;
    d.rxline = RXD;
    // Memory routing of fetches.
    if (EXTERNAL_ACCESS_N == 1'b0)
      d.ext = 1'b1;
    else if (FETCH_ADDR >= `BSSL_BOOT_ROM_BASE)
      d.ext = 1'b0;
    else
      d.ext = FETCH_ADDR > (FLASH_32K ? `BSSL_FLASH_TOP_32K
                                      : `BSSL_FLASH_TOP_16K);
    d.rom = EXTERNAL_ACCESS_N
            && FETCH_ADDR >= `BSSL_BOOT_ROM_BASE;
    // Boot decision at the reset fall.
    if (RESET_FALL)
    begin
      d.sv = 1'b1;
      d.act = 1'b0;
      d.hold = `BSSL_STRAP_HOLD_CYC;
      if (!PROGRAM_STORE_STROBE_N && EXTERNAL_ACCESS_N && ADDR_LATCH_EN)
      begin
        d.start = {`BSSL_SBV_DEFAULT, 8'h00};
        d.act = 1'b1;
      end
      else if (BOOT_LOADER_JUMP_BIT)
        d.start = `BSSL_APP_START;
      else if (BOOT_STATUS_BYTE == 8'h00)
        d.start = `BSSL_APP_START;
      else
      begin
        d.start = {SOFTWARE_BOOT_VECTOR, 8'h00};
        d.act = (SOFTWARE_BOOT_VECTOR == `BSSL_SBV_DEFAULT);
      end
    end
    else if (q.hold != 5'd0)
      d.hold = q.hold - 5'd1;
    // Receiver: 8N1, one sample per bit at mid-bit.
    d.rxcnt = q.rxcnt + 16'd1;
    unique case (q.rxs)
      BSSL_RX_IDLE:
        if (!q.rxline && q.st != BSSL_BAUD_IDLE && q.st != BSSL_BAUD_MEAS)
        begin
          d.rxs = BSSL_RX_START;
          d.rxcnt = 16'd0;
        end
      BSSL_RX_START:
        if (q.rxcnt == {1'b0, q.bitlen[15:1]})
        begin
          d.rxs = BSSL_RX_DATA;
          d.rxcnt = 16'd0;
          d.rxbit = 4'd0;
        end
      BSSL_RX_DATA:
        if (q.rxcnt == q.bitlen)
        begin
          d.rxcnt = 16'd0;
          d.rxsh = {q.rxline, q.rxsh[7:1]};
          d.rxbit = q.rxbit + 4'd1;
          if (q.rxbit == 4'd7)
            d.rxs = BSSL_RX_STOP;
        end
      BSSL_RX_STOP:
        if (q.rxcnt == q.bitlen)
          d.rxs = BSSL_RX_IDLE;
    endcase
    // Echo every received character.
    if (rx_done && q.act)
    begin
      push = f_rdy;
      push_data = rx_byte;
    end
    // Record interpreter.
    unique case (q.st)
      BSSL_BAUD_IDLE:
        if (q.act && q.hold == 5'd0 && !q.rxline)
        begin
          d.st = BSSL_BAUD_MEAS;
          d.bitlen = 16'd0;
        end
      BSSL_BAUD_MEAS:
        // The start bit of U is one bit long; count it.
        if (q.rxline)
        begin
          d.st = BSSL_WAIT_COLON;
          d.rxs = BSSL_RX_DATA;
          d.rxcnt = q.bitlen - {1'b0, q.bitlen[15:1]};
          d.rxbit = 4'd0;
        end
        else
          d.bitlen = q.bitlen + 16'd1;
      BSSL_WAIT_COLON:
        if (rx_done && rx_byte == `BSSL_CH_COLON)
        begin
          d.st = BSSL_GET_HEX;
          d.idx = 6'd0;
          d.hinib = 1'b1;
          d.sum = 8'h00;
        end
      BSSL_GET_HEX:
        if (rx_done && hv[4])
          d.st = BSSL_WAIT_COLON;
        else if (rx_done && q.hinib)
        begin
          d.nib = hv[3:0];
          d.hinib = 1'b0;
        end
        else if (rx_done)
        begin
          d.hinib = 1'b1;
          d.idx = q.idx + 6'd1;
          d.sum = q.sum + byte_v;
          if (q.idx == 6'd0)
            d.cnt = byte_v;
          if (q.idx == 6'd1)
            d.addr[15:8] = byte_v;
          if (q.idx == 6'd2)
            d.addr[7:0] = byte_v;
          if (q.idx == 6'd3)
            d.rtyp = byte_v;
          if (q.idx >= 6'd4 && q.idx < 6'd20)
            d.dat[4'(q.idx - 6'd4)] = byte_v;
          if (q.idx == 6'd0 && byte_v > `BSSL_MAX_DATA)
            d.st = BSSL_WAIT_COLON;
          if (q.idx == 6'(q.cnt + 8'd4) && q.idx != 6'd0)
            d.st = BSSL_EXEC;
        end
      BSSL_EXEC:
        if (f_rdy && !push)
        begin
          d.st = BSSL_REPLY;
          if (q.sum != 8'h00)
            push_data = `BSSL_CH_X;
          else if (q.rtyp == `BSSL_REC_DATA && q.cnt != 8'h00)
          begin
            d.st = BSSL_PROG;
            d.pi = 5'd0;
            d.fail = 1'b0;
          end
          else
            push_data = `BSSL_CH_DOT;
          push = (d.st == BSSL_REPLY);
        end
      BSSL_PROG:
      begin
        d.preq = 1'b1;
        d.paddr = q.addr + 16'(q.pi);
        d.pdat = q.dat[q.pi[3:0]];
        d.st = BSSL_WAIT_ACK;
      end
      BSSL_WAIT_ACK:
        if (PROG_DONE)
        begin
          d.fail = q.fail | !PROG_OK;
          d.pi = q.pi + 5'd1;
          d.st = (8'(q.pi + 5'd1) == q.cnt) ? BSSL_EXEC : BSSL_PROG;
          if (8'(q.pi + 5'd1) == q.cnt)
            d.rtyp = 8'hff;
        end
      BSSL_REPLY:
        d.st = BSSL_WAIT_COLON;
    endcase
    // Data record finished: answer from the program result.
    if (q.st == BSSL_EXEC && q.rtyp == 8'hff && q.sum == 8'h00)
    begin
      push_data = q.fail ? `BSSL_CH_R : `BSSL_CH_DOT;
    end
    // Transmitter at the learned rate.
    if (!q.txbusy && f_vld && f_take)
    begin
      d.txbusy = 1'b1;
      d.txsh = {1'b1, f_data, 1'b0};
      d.txbit = 4'd0;
      d.txcnt = 16'd0;
    end
    else if (q.txbusy)
    begin
      d.txd = q.txsh[0];
      d.txcnt = q.txcnt + 16'd1;
      if (q.txcnt == q.bitlen)
      begin
        d.txcnt = 16'd0;
        d.txsh = {1'b1, q.txsh[9:1]};
        d.txbit = q.txbit + 4'd1;
        if (q.txbit == 4'd9)
          d.txbusy = 1'b0;
      end
    end
    else
      d.txd = 1'b1;
  end

  // Registers every field of the state.
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      q <= '0;
      q.st <= BSSL_BAUD_IDLE;
      q.rxs <= BSSL_RX_IDLE;
      q.rxline <= 1'b1;
      q.txd <= 1'b1;
      q.bitlen <= 16'd1;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign FETCH_EXTERNAL = q.ext;
  assign FETCH_BOOT_ROM = q.rom;
  assign START_ADDR = q.start;
  assign START_VALID = q.sv;
  assign LOADER_ACTIVE = q.act;
  assign TXD = q.txd;
  assign PROG_REQ = q.preq;
  assign PROG_ADDR = q.paddr;
  assign PROG_DATA = q.pdat;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_ext_low;
    @(posedge SYS_CLK) disable iff (!RST_N)
    !EXTERNAL_ACCESS_N |=> FETCH_EXTERNAL;
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("EA low not ext");
  property p_rom;
    @(posedge SYS_CLK) disable iff (!RST_N)
    EXTERNAL_ACCESS_N && FETCH_ADDR >= 16'hf800 |=> FETCH_BOOT_ROM;
  endproperty
  a_rom: assert property (p_rom) else $error("Boot ROM missed");
  property p_flash;
    @(posedge SYS_CLK) disable iff (!RST_N)
    EXTERNAL_ACCESS_N && FETCH_ADDR <= 16'h3fff |=> !FETCH_EXTERNAL;
  endproperty
  a_flash: assert property (p_flash) else $error("Flash fetch ext");
  property p_jump;
    @(posedge SYS_CLK) disable iff (!RST_N)
    RESET_FALL && BOOT_LOADER_JUMP_BIT && PROGRAM_STORE_STROBE_N
      |=> START_ADDR == 16'h0000;
  endproperty
  a_jump: assert property (p_jump) else $error("Jump bit ignored");
  property p_bsb0;
    @(posedge SYS_CLK) disable iff (!RST_N)
    RESET_FALL && PROGRAM_STORE_STROBE_N && BOOT_STATUS_BYTE == 8'h00
      |=> START_ADDR == 16'h0000;
  endproperty
  a_bsb0: assert property (p_bsb0) else $error("Zero status wrong");
  property p_vec;
    @(posedge SYS_CLK) disable iff (!RST_N)
    RESET_FALL && PROGRAM_STORE_STROBE_N && !BOOT_LOADER_JUMP_BIT
      && BOOT_STATUS_BYTE != 8'h00
      |=> START_ADDR == {$past(SOFTWARE_BOOT_VECTOR), 8'h00};
  endproperty
  a_vec: assert property (p_vec) else $error("Vector wrong");
  property p_strap;
    @(posedge SYS_CLK) disable iff (!RST_N)
    RESET_FALL && !PROGRAM_STORE_STROBE_N && EXTERNAL_ACCESS_N
      && ADDR_LATCH_EN |=> LOADER_ACTIVE && START_ADDR == 16'hfc00;
  endproperty
  a_strap: assert property (p_strap) else $error("Strap ignored");
  property p_prog_only_good;
    @(posedge SYS_CLK) disable iff (!RST_N)
    q.st == BSSL_EXEC && q.sum != 8'h00 |=> q.st != BSSL_PROG;
  endproperty
  a_prog_only_good: assert property (p_prog_only_good)
    else $error("Bad record run");
  c_strap: cover property (@(posedge SYS_CLK) RESET_FALL
    && !PROGRAM_STORE_STROBE_N && EXTERNAL_ACCESS_N && ADDR_LATCH_EN);
  c_prog: cover property (@(posedge SYS_CLK) PROG_REQ);
  c_bad: cover property (@(posedge SYS_CLK) push && push_data == 8'h58);
endmodule : bssl_loader
`default_nettype wire

// ===== dv/bssl_host_model.sv
// Serial host model that sends characters and decodes the replies.
`timescale 1ns/1ps
`default_nettype none
module bssl_host_model #(
  parameter int BIT = 40
) (
  input wire logic clk, // System clock.
  input wire logic txd, // Line from the device.
  output logic rxd // Line into the device, idle high.
);
  logic [7:0] rxq[$];
  logic [7:0] sh;

  // The line idles at mark level until a frame starts.
  initial rxd = 1'b1;

  // Sends one 8N1 frame, lsb first, then two idle bit times.
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int b = 0; b < 10; b++)
      repeat (BIT) @(posedge clk) rxd <= f[b];
    repeat (2 * BIT) @(posedge clk);
  endtask : send

  // Decodes frames from the device, sampling each bit near its middle.
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT + 1) @(posedge clk);
      sh[i] = txd;
    end
    rxq.push_back(sh);
    repeat (BIT) @(posedge clk);
  end
endmodule : bssl_host_model
`default_nettype wire

// ===== dv/test_boot_select_serial_loader.sv
// Self-checking testbench of the boot selector and serial loader.
`timescale 1ns/1ps
`default_nettype none
`include "bssl_consts.svh"
`define BSSL_CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module test_boot_select_serial_loader;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int BIT = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rfall = 1'b0;
  logic ea_n = 1'b1;
  logic program_store_strobe_n_n = 1'b1;
  logic ale = 1'b1;
  logic jb = 1'b0;
  logic pdone = 1'b0;
  logic pok = 1'b1;
  logic [7:0] boot_status_byte = 8'hff;
  logic [7:0] software_boot_vector = 8'hfc;
  logic [15:0] faddr = 16'h0000;
  logic rxd, fext, from, sval, lact, txd, preq;
  logic [15:0] saddr, paddr;
  logic [7:0] pdata;
  logic [23:0] progq[$];
  logic [15:0] fa[7] = '{16'h0000, 16'h3fff, 16'h7fff, 16'h8000,
                         16'hf7ff, 16'hf800, 16'hffff};
  int error_cnt = 0;
  int num_checks = 0;

  // Free-running core clock.
  always #2 clk = ~clk;

  // Loader and its serial host.
  bssl_loader dut (.SYS_CLK(clk), .RST_N(rst_n), .RESET_FALL(rfall),
    .EXTERNAL_ACCESS_N(ea_n), .PROGRAM_STORE_STROBE_N(program_store_strobe_n_n),
    .ADDR_LATCH_EN(ale), .BOOT_LOADER_JUMP_BIT(jb),
    .BOOT_STATUS_BYTE(boot_status_byte), .SOFTWARE_BOOT_VECTOR(software_boot_vector),
    .FETCH_ADDR(faddr), .RXD(rxd), .PROG_DONE(pdone), .PROG_OK(pok),
    .FETCH_EXTERNAL(fext), .FETCH_BOOT_ROM(from), .START_ADDR(saddr),
    .START_VALID(sval), .LOADER_ACTIVE(lact), .TXD(txd),
    .PROG_REQ(preq), .PROG_ADDR(paddr), .PROG_DATA(pdata));
  bssl_host_model #(.BIT(BIT)) host (.clk(clk), .txd(txd), .rxd(rxd));

  // Flash side: logs each byte write and answers it three cycles later.
  always @(posedge clk)
    if (preq === 1'b1)
    begin
      progq.push_back({paddr, pdata});
      repeat (3) @(posedge clk);
      pdone <= 1'b1;
      @(posedge clk) pdone <= 1'b0;
    end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Checks the outputs just after reset, before any boot decision.
  task automatic reset_test;
    @(posedge clk);
    @(posedge clk);
    #1;
    `BSSL_CHK(txd, 1'b1)
    `BSSL_CHK(sval, 1'b0)
    `BSSL_CHK(lact, 1'b0)
    `BSSL_CHK(preq, 1'b0)
    `BSSL_CHK(fext, 1'b0)
    $display("Reset test done");
  endtask : reset_test

  // Presents one fetch address and checks where it is routed.
  task automatic fetch(input logic e, input logic [15:0] a);
    @(posedge clk);
    ea_n <= e;
    faddr <= a;
    @(posedge clk);
    #1;
    if (!e || a < `BSSL_BOOT_ROM_BASE)
      `BSSL_CHK(fext, !e || a > `BSSL_FLASH_TOP_32K)
    if (e)
      `BSSL_CHK(from, a >= `BSSL_BOOT_ROM_BASE)
  endtask : fetch

  // Pulses the reset fall with the given settings and straps.
  task automatic boot(input logic j, input logic [7:0] st, v,
                      input logic ps, al);
    logic frc;
    logic act;
    frc = !ps && al;
    act = frc || (!j && st != 8'h00 && v == `BSSL_SBV_DEFAULT);
    @(posedge clk);
    jb <= j;
    boot_status_byte <= st;
    software_boot_vector <= v;
    program_store_strobe_n_n <= ps;
    ale <= al;
    rfall <= 1'b1;
    @(posedge clk);
    rfall <= 1'b0;
    repeat (`BSSL_STRAP_HOLD_CYC) @(posedge clk);
    program_store_strobe_n_n <= 1'b1;
    @(posedge clk);
    #1;
    `BSSL_CHK(sval, 1'b1)
    `BSSL_CHK(lact, act)
    if (!frc)
      `BSSL_CHK(saddr, j || !st ? `BSSL_APP_START : {v, 8'h00})
  endtask : boot

  // Sends a string, waits for echo plus reply, and checks the echo.
  task automatic rec(input string s, input logic [7:0] rep);
    int n;
    int k;
    n = s.len() + int'(rep != 8'h00);
    host.rxq.delete();
    progq.delete();
    for (int i = 0; i < s.len(); i++)
      host.send(s[i]);
    for (k = 0; k < 3000 && host.rxq.size() < n; k++)
      @(posedge clk);
    if (k == 3000)
    begin
      error_cnt++;
      end_of_test();
    end
    repeat (12 * BIT) @(posedge clk);
    `BSSL_CHK(host.rxq.size(), n)
    for (int i = 0; i < s.len(); i++)
      `BSSL_CHK(host.rxq[i], s[i])
    if (rep != 8'h00)
      `BSSL_CHK(host.rxq[n - 1], rep)
  endtask : rec

  // Good records of every documented type, a bad-checksum type 01 record and malformed ones.
  task automatic serial_test;
    rec("U", 8'h00);
    rec(":11000000", 8'h00);
    rec(":0G", 8'h00);
    rec(":00000001FF", `BSSL_CH_DOT);
    rec("\r\n", 8'h00);
    rec(":00000001FE", `BSSL_CH_X);
    rec(":0100000210ED", `BSSL_CH_DOT);
    `BSSL_CHK(progq.size(), 0)
    rec(":02012300AABB75", `BSSL_CH_DOT);
    `BSSL_CHK(progq.size(), 2)
    `BSSL_CHK(progq[0], 24'h0123aa)
    `BSSL_CHK(progq[1], 24'h0124bb)
    @(posedge clk);
    pok <= 1'b0;
    rec(":010040005A65", `BSSL_CH_R);
    `BSSL_CHK(progq.size(), 1)
    $display("Serial test done");
  endtask : serial_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reset_test();
    foreach (fa[i])
    begin
      fetch(1'b1, fa[i]);
      fetch(1'b0, fa[i]);
    end
    fetch(1'b1, 16'h0000);
    $display("Fetch test done");
    boot(1'b1, 8'hff, 8'hfc, 1'b1, 1'b1);
    boot(1'b0, 8'h00, 8'hfc, 1'b1, 1'b1);
    boot(1'b0, 8'hff, 8'h3c, 1'b1, 1'b1);
    boot(1'b0, 8'hff, 8'hfc, 1'b1, 1'b1);
    boot(1'b1, 8'hff, 8'hfc, 1'b0, 1'b0);
    boot(1'b1, 8'h00, 8'h12, 1'b0, 1'b1);
    $display("Boot test done");
    serial_test();
    end_of_test();
  end
endmodule : test_boot_select_serial_loader
`default_nettype wire
